// ===== logic/pst_pkg.sv
// package: constants and types of the phase-selective trip logic
package pst_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 10000000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] MIN_PULSE_MS_RST = 16'h0096;
  localparam logic [15:0] EVOLVE_MS_RST = 16'h03E8;
  localparam logic [15:0] SETTING_MS_MIN = 16'h0032;
  localparam logic [15:0] SETTING_MS_MAX = 16'hEA60;
  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    PST_MODE_OFF = 2'h0,
    PST_MODE_3PH = 2'h1,
    PST_MODE_1PH3PH = 2'h2
  } pst_mode_t;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic block;
    logic single_phase;
    logic three_phase;
    logic force_all;
    logic [2:0] select;
  } pst_req_t;
  typedef struct packed {
    logic [2:0] phase;
    logic general;
    logic all_phase;
  } pst_trip_t;
endpackage

// ===== logic/pst_trip_logic.sv
// module: phase-selective trip decision logic
// Functional notes
// (RULE1) modes off, three-phase only, single/three-phase; off at reset; mode is an input here and reset does not set it
// (RULE2) each trip held at least minimum pulse length, default 150 ms
// (RULE3) two faulted phases also trip the third phase
// (RULE4) force input turns any trip into a three-phase trip
// (RULE5) trip inside evolving-fault window after a trip goes three-phase
// (RULE6) blocking input holds all trip outputs inactive
// (RULE7) requester raises single-phase request for single-phase trips
// (RULE8) requester raises three-phase request for three-phase trips
// (RULE9) requester marks the concerned phases on the select inputs
// (RULE10) separate trip output per phase
// (RULE11) general trip whenever any trip is generated
// (RULE12) all-phase trip output when all three phases trip
// (RULE13) every change of phase and general outputs gives an on/off event
// (RULE14) mode off produces no trip at all
// (RULE15) three-phase mode trips all phases; combined mode keeps single phase
// (RULE16) timers counted on a millisecond tick from the clock
module pst_trip_logic (
  input wire logic clk,
  input wire logic rstn,
  input wire pst_pkg::pst_mode_t mode,
  input wire logic [15:0] min_pulse_ms,
  input wire logic [15:0] evolve_ms,
  input wire logic trip_block_in,
  input wire logic single_phase_request_in,
  input wire logic three_phase_request_in,
  input wire logic phase1_select_in,
  input wire logic phase2_select_in,
  input wire logic phase3_select_in,
  input wire logic force_all_phases_in,
  output logic phase1_trip_out,
  output logic phase2_trip_out,
  output logic phase3_trip_out,
  output logic general_trip_out,
  output logic all_phase_trip_out,
  output logic [3:0] event_valid,
  output logic [3:0] event_state
);
  import pst_pkg::*;

  // ==========================================================
  // input synchronisers
  pst_req_t s1_ff, s2_ff, nxt_s1;
  always_comb begin
    nxt_s1 = '{trip_block_in, single_phase_request_in, three_phase_request_in,
      force_all_phases_in, {phase3_select_in, phase2_select_in, phase1_select_in}};
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= s1_ff;
    end
  end

  function automatic logic [15:0] clamp_ms(input logic [15:0] v);
    // out-of-range settings are clamped rather than trusted
    if (v < SETTING_MS_MIN) return SETTING_MS_MIN;
    if (v > SETTING_MS_MAX) return SETTING_MS_MAX;
    return v;
  endfunction

  // ==========================================================
  // millisecond tick
  logic [13:0] div_ff, nxt_div;
  logic tick;
  always_comb begin
    tick = (div_ff == 14'(MS_CYCLES - 1)); // see (RULE16)
    nxt_div = tick ? 14'h0000 : div_ff + 14'h0001;
  end

  // ==========================================================
  // decision
  logic [2:0] req_ph;
  logic req_any, req_all;
  // window state is read here, so it is declared ahead of the stretch section
  logic [15:0] pulse_ff, nxt_pulse, evo_ff, nxt_evo;
  logic req_prev_ff, nxt_req_prev;
  always_comb begin
    req_ph = 3'h0;
    req_any = 1'b0;
    req_all = 1'b0;
    if (mode != PST_MODE_OFF && !s2_ff.block) begin // see (RULE14) see (RULE6)
      req_any = s2_ff.three_phase || (s2_ff.single_phase && s2_ff.select != 3'h0);
      req_all = s2_ff.three_phase || mode == PST_MODE_3PH // see (RULE15)
        || s2_ff.force_all // see (RULE4)
        // only a fresh request escalates; a held one stays phase-selective
        || (evo_ff != 16'h0000 && !req_prev_ff) // see (RULE5)
        || (s2_ff.select[0] + s2_ff.select[1] + s2_ff.select[2] >= 2'h2); // see (RULE3)
      if (req_any) req_ph = req_all ? 3'h7 : s2_ff.select; // see (RULE15)
    end
  end

  // ==========================================================
  // pulse stretch and evolving window
  logic [2:0] hold_ph_ff, nxt_hold_ph;
  logic [2:0] out_ph;
  always_comb begin
    nxt_hold_ph = hold_ph_ff;
    nxt_pulse = pulse_ff;
    nxt_evo = evo_ff;
    nxt_req_prev = req_any;
    if (req_any) begin
      nxt_hold_ph = hold_ph_ff | req_ph; // see (RULE2)
      nxt_pulse = clamp_ms(min_pulse_ms);
      nxt_evo = clamp_ms(evolve_ms); // see (RULE5)
    end else begin
      if (tick && pulse_ff != 16'h0000) nxt_pulse = pulse_ff - 16'h0001;
      if (pulse_ff == 16'h0000) nxt_hold_ph = 3'h0;
      if (tick && evo_ff != 16'h0000) nxt_evo = evo_ff - 16'h0001;
    end
    if (mode == PST_MODE_OFF) begin // see (RULE1)
      nxt_hold_ph = 3'h0;
      nxt_pulse = 16'h0000;
      nxt_evo = 16'h0000;
    end
    // blocking masks the outputs; the stretch itself keeps running
    out_ph = (s2_ff.block || mode == PST_MODE_OFF) ? 3'h0 : nxt_hold_ph; // see (RULE6)
  end

  // ==========================================================
  // outputs and events
  pst_trip_t out_ff, nxt_out;
  always_comb begin
    nxt_out.phase = out_ph; // see (RULE10)
    nxt_out.general = out_ph != 3'h0; // see (RULE11)
    nxt_out.all_phase = out_ph == 3'h7; // see (RULE12)
  end
  logic [3:0] nxt_ev_valid, nxt_ev_state, ev_valid_ff, ev_state_ff;
  always_comb begin
    nxt_ev_state = {nxt_out.general, nxt_out.phase};
    nxt_ev_valid = nxt_ev_state ^ {out_ff.general, out_ff.phase}; // see (RULE13)
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 14'h0000;
      hold_ph_ff <= 3'h0;
      pulse_ff <= 16'h0000;
      evo_ff <= 16'h0000;
      req_prev_ff <= 1'b0;
      out_ff <= '0;
      ev_valid_ff <= 4'h0;
      ev_state_ff <= 4'h0;
    end else begin
      div_ff <= nxt_div;
      hold_ph_ff <= nxt_hold_ph;
      pulse_ff <= nxt_pulse;
      evo_ff <= nxt_evo;
      req_prev_ff <= nxt_req_prev;
      out_ff <= nxt_out;
      ev_valid_ff <= nxt_ev_valid;
      ev_state_ff <= nxt_ev_state;
    end
  end

  assign phase1_trip_out = out_ff.phase[0];
  assign phase2_trip_out = out_ff.phase[1];
  assign phase3_trip_out = out_ff.phase[2];
  assign general_trip_out = out_ff.general;
  assign all_phase_trip_out = out_ff.all_phase;
  assign event_valid = ev_valid_ff;
  assign event_state = ev_state_ff;

  // ==========================================================
  // checks
  property p_block;
    @(posedge clk) disable iff (!rstn) s2_ff.block |=> !general_trip_out;
  endproperty
  a_block: assert property (p_block) else $error("trip while blocked"); // see (RULE6)
  property p_off;
    @(posedge clk) disable iff (!rstn) mode == PST_MODE_OFF |=> !general_trip_out;
  endproperty
  a_off: assert property (p_off) else $error("trip in off mode"); // see (RULE14)
  property p_gen;
    @(posedge clk) disable iff (!rstn)
      general_trip_out == (phase1_trip_out | phase2_trip_out | phase3_trip_out);
  endproperty
  a_gen: assert property (p_gen) else $error("general trip mismatch"); // see (RULE11)
  property p_all;
    @(posedge clk) disable iff (!rstn)
      all_phase_trip_out == (phase1_trip_out & phase2_trip_out & phase3_trip_out);
  endproperty
  a_all: assert property (p_all) else $error("all-phase mismatch"); // see (RULE12)
  property p_force;
    @(posedge clk) disable iff (!rstn)
      req_any && s2_ff.force_all |=> all_phase_trip_out;
  endproperty
  a_force: assert property (p_force) else $error("force not three-phase"); // see (RULE4)
  property p_two;
    @(posedge clk) disable iff (!rstn)
      req_any && s2_ff.select == 3'h3 |=> phase3_trip_out;
  endproperty
  a_two: assert property (p_two) else $error("third phase missing"); // see (RULE3)
  property p_3ph;
    @(posedge clk) disable iff (!rstn)
      req_any && mode == PST_MODE_3PH |=> all_phase_trip_out;
  endproperty
  a_3ph: assert property (p_3ph) else $error("three-phase mode not all"); // see (RULE15)
  property p_evolve;
    @(posedge clk) disable iff (!rstn)
      req_any && !req_prev_ff && evo_ff != 16'h0000 |=> all_phase_trip_out;
  endproperty
  a_evolve: assert property (p_evolve) else $error("evolving fault not three-phase"); // see (RULE5)
  property p_hold;
    @(posedge clk) disable iff (!rstn)
      $fell(req_any) && mode != PST_MODE_OFF && !s2_ff.block
      |=> general_trip_out
      ##1 (general_trip_out || $past(s2_ff.block) || $past(mode) == PST_MODE_OFF);
  endproperty
  a_hold: assert property (p_hold) else $error("pulse not held"); // see (RULE2)
  property p_event;
    @(posedge clk) disable iff (!rstn)
      $changed(general_trip_out) |-> event_valid[3] && event_state[3] == general_trip_out;
  endproperty
  a_event: assert property (p_event) else $error("event missing"); // see (RULE13)
  c_single: cover property (@(posedge clk) disable iff (!rstn)
    general_trip_out && !all_phase_trip_out);
  c_three: cover property (@(posedge clk) disable iff (!rstn) all_phase_trip_out);
  c_evolve: cover property (@(posedge clk) disable iff (!rstn)
    req_any && !req_prev_ff && evo_ff != 16'h0000 && !s2_ff.three_phase);
endmodule

// ===== tb/pst_requester.sv
// partner model: protection logic raising trip requests
module pst_requester (
  input wire pst_pkg::pst_req_t cmd,
  output logic trip_block_in,
  output logic single_phase_request_in,
  output logic three_phase_request_in,
  output logic phase1_select_in,
  output logic phase2_select_in,
  output logic phase3_select_in,
  output logic force_all_phases_in
);
  import pst_pkg::*;
  // ==========================================================
  // request pins
  assign trip_block_in = cmd.block;
  assign single_phase_request_in = cmd.single_phase;
  assign three_phase_request_in = cmd.three_phase;
  assign {phase3_select_in, phase2_select_in, phase1_select_in} = cmd.select;
  assign force_all_phases_in = cmd.force_all;
endmodule

// ===== tb/pst_trip_logic_tb.sv
// testbench: trip logic against a behavioural model
module pst_trip_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pst_pkg::*;
  // ==========================================================
  // signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pst_mode_t mode = PST_MODE_OFF;
  pst_req_t cmd = '0;
  pst_req_t q;
  logic blk, r1, r3, s1, s2, s3, frc, gen, all3;
  logic [2:0] ph;
  logic [3:0] ev_valid, ev_state, ev_acc = '0;
  logic [4:0] exp;
  int n_mismatch = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  // negedge: registered pulses have settled
  always @(negedge clk) ev_acc <= rstn ? (ev_acc | ev_valid) : 4'h0;
  pst_requester req (.cmd(cmd), .trip_block_in(blk), .single_phase_request_in(r1),
    .three_phase_request_in(r3), .phase1_select_in(s1), .phase2_select_in(s2),
    .phase3_select_in(s3), .force_all_phases_in(frc));
  pst_trip_logic uut (.clk(clk), .rstn(rstn), .mode(mode), .min_pulse_ms(MIN_PULSE_MS_RST),
    .evolve_ms(EVOLVE_MS_RST), .trip_block_in(blk), .single_phase_request_in(r1),
    .three_phase_request_in(r3), .phase1_select_in(s1), .phase2_select_in(s2),
    .phase3_select_in(s3), .force_all_phases_in(frc), .phase1_trip_out(ph[0]),
    .phase2_trip_out(ph[1]), .phase3_trip_out(ph[2]), .general_trip_out(gen),
    .all_phase_trip_out(all3), .event_valid(ev_valid), .event_state(ev_state));
  // ==========================================================
  // model and checks
  function automatic logic [4:0] model(pst_mode_t m, pst_req_t r, logic evolve);
    int n;
    logic [2:0] p;
    n = r.select[0] + r.select[1] + r.select[2];
    if (m == PST_MODE_OFF || r.block || !(r.three_phase || (r.single_phase && n > 0)))
      return 5'h00;
    p = (m == PST_MODE_3PH || r.three_phase || r.force_all || n > 1 || evolve) ? 3'h7 : r.select;
    return {p, 1'b1, &p};
  endfunction
  task automatic cmp_trip(input logic [4:0] e);
    n_tests++;
    if ({ph, gen, all3} !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: trips %b, model %b", $time, {ph, gen, all3}, e);
    end
  endtask
  task automatic cmp_event(input logic [3:0] e, input logic [3:0] s);
    n_tests++;
    if (ev_acc !== e || ev_state !== s) begin
      n_mismatch++;
      $display("unexpected at %0t: events %b state %b, model %b %b",
        $time, ev_acc, ev_state, e, s);
    end
  endtask
  task automatic restart(input pst_mode_t m);
    @(posedge clk);
    rstn <= 1'b0;
    cmd <= '0;
    mode <= m;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
  initial begin
    void'($urandom(32'hC05D531F));
    for (int i = 0; i < 48; i++) begin
      q = 7'($urandom);
      if (i % 5 != 0) q.block = 1'b0; // blocking kept rare
      restart(pst_mode_t'(i % 3));
      cmd <= q;
      repeat (8) @(posedge clk);
      @(negedge clk);
      exp = model(pst_mode_t'(i % 3), q, 1'b0);
      cmp_trip(exp);
      cmp_event({exp[1], exp[4:2]}, {exp[1], exp[4:2]});
    end
    // short request on L1, then a second fault inside the window
    restart(PST_MODE_1PH3PH);
    cmd <= 7'h21;
    @(posedge clk);
    cmd <= '0;
    repeat (2000) @(posedge clk);
    @(negedge clk);
    cmp_trip(5'h06);
    cmp_event(4'h9, 4'h9);
    @(posedge clk);
    cmd <= 7'h22;
    repeat (8) @(posedge clk);
    @(negedge clk);
    cmp_trip(5'h1F);
    cmp_event(4'hF, 4'hF);
    conclude();
  end
endmodule
